// ==== test/bscan_tap_chk.sv ====
// concurrent checks on the boundary-scan tap, seen from its own ports
module bscan_tap_chk #(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_BD = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic trst_n_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic [N_OUT-1:0] core_out_in,
  input wire logic [N_OUT-1:0] out_pin_out,
  input wire logic out_pin_oe_out,
  input wire logic [N_BD-1:0] bd_pin_out,
  input wire logic bd_pin_oe_out,
  input wire logic [N_IN-1:0] core_in_out,
  input wire logic internal_scan_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [N_OUT+N_BD+1:0] pins_seen;
  assign pins_seen = {out_pin_out, out_pin_oe_out, bd_pin_out, bd_pin_oe_out};
  // tck is sampled late, so anything launched at a fall lands while the pin is still low
  a_tdo_fall_only: assert property ($changed(tdo_out) |-> !tck_in)
    else $error("tdo moved while tck high");
  a_tdo_hold_rise: assert property ($rose(tck_in) |-> $stable(tdo_out) [*8])
    else $error("tdo moved after a tck rise");
  a_oe_fall_only: assert property ($changed(tdo_oe_out) |-> !tck_in)
    else $error("tdo enable moved while tck high");
  a_pins_fall_only: assert property ($changed(pins_seen) |-> !tck_in)
    else $error("pin outputs moved while tck high");
  a_core_in_fall: assert property ($changed(core_in_out) |-> !tck_in)
    else $error("core inputs moved while tck high");
  a_scan_mode_fall: assert property ($changed(internal_scan_out) |-> !tck_in)
    else $error("scan mode moved while tck high");
  a_reset_clear: assert property ($rose(rst_n_in) |-> !tdo_oe_out && !internal_scan_out && !out_pin_oe_out)
    else $error("outputs not cleared by reset");
  a_trst_normal: assert property ((!trst_n_in && $stable(core_out_in)) [*8] |->
    out_pin_out == core_out_in && !internal_scan_out)
    else $error("test reset left a test mode active");
  // main scenarios reached
  c_scan_mode: cover property ($rose(internal_scan_out));
  c_shift: cover property ($rose(tdo_oe_out));
  c_trst: cover property ($fell(trst_n_in));
endmodule : bscan_tap_chk

bind bscan_tap bscan_tap_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .N_BD(N_BD)) chk_i (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tck_in(tck_in), .trst_n_in(trst_n_in),
  .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .core_out_in(core_out_in), .out_pin_out(out_pin_out),
  .out_pin_oe_out(out_pin_oe_out), .bd_pin_out(bd_pin_out), .bd_pin_oe_out(bd_pin_oe_out),
  .core_in_out(core_in_out), .internal_scan_out(internal_scan_out)
);

// ==== test/jtag_master.sv ====
// external test master: drives the tap pins and samples tdo
module jtag_master (
  input wire logic core_clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // tck rests low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    trst_n_out = 1'b1;
  end
  // one 160 ns tck period; tdo read just before the rise, after it settled from the fall
  task automatic tick(input logic ms, input logic di, output logic so);
    tms_out = ms;
    tdi_out = di;
    repeat (20) @(negedge core_clk_in);
    so = tdo_in;
    tck_out = 1'b1;
    repeat (20) @(negedge core_clk_in);
    tck_out = 1'b0;
  endtask : tick
  // five highs on mode select reach reset from anywhere, then idle
  task automatic reset5();
    logic s;
    repeat (5) tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : reset5
  // scan n bits through the instruction or data path, idle to idle
  task automatic shift(input int n, input logic ir, input logic [15:0] din, output logic [15:0] dout);
    logic s;
    dout = '0;
    tick(1'b1, 1'b0, s);
    if (ir) tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : shift
  // test reset pulse, long enough for the synchroniser
  task automatic pulse_trst();
    trst_n_out = 1'b0;
    repeat (20) @(negedge core_clk_in);
    trst_n_out = 1'b1;
    repeat (8) @(negedge core_clk_in);
  endtask : pulse_trst
endmodule : jtag_master

// ==== test/testbench.sv ====
// self-checking bench for the boundary-scan tap
`include "bscan_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] P = 16'h2e96;
  localparam logic [15:0] R = 16'h15a3;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, out_oe, bd_oe_out, iscan;
  logic core_oe = 1'b1;
  logic bd_oe = 1'b0;
  logic [3:0] in_pin = 4'h9;
  logic [3:0] core_out = 4'h6;
  logic [3:0] bd_ext = 4'h3;
  logic [3:0] bd_core = 4'hc;
  logic [3:0] bd_pin, out_pin, core_in, bd_out, bd_core_in;
  logic [15:0] d;
  logic tdo_line;
  int errors = 0;
  int n_checks = 0;
  // core clock, 4 ns
  always #2 core_clk_in = ~core_clk_in;
  // bidir wire: the tap wins while it drives
  assign bd_pin = bd_oe_out ? bd_out : bd_ext;
  // tdo has no pull: a released line reads inverted so a sample taken while floating is caught
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  bscan_tap dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .in_pin_in(in_pin), .core_in_out(core_in),
    .core_out_in(core_out), .core_out_oe_in(core_oe), .out_pin_out(out_pin), .out_pin_oe_out(out_oe),
    .bd_pin_in(bd_pin), .bd_core_out_in(bd_core), .bd_core_oe_in(bd_oe), .bd_pin_out(bd_out),
    .bd_pin_oe_out(bd_oe_out), .bd_core_in_out(bd_core_in), .internal_scan_out(iscan)
  );
  jtag_master tm (
    .core_clk_in(core_clk_in), .tdo_in(tdo_line), .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n)
  );
  // compare one observed value with its expectation
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // load an instruction; the fixed capture pattern comes back out
  task automatic ir(input logic [4:0] code);
    tm.shift(5, 1'b1, {11'h0, code}, d);
    chk(d, 16'h000d);
  endtask : ir
  // after reset: one-bit path, pins follow the core
  task automatic t_bypass();
    tm.shift(4, 1'b0, 16'h000b, d);
    chk(d, 16'h0006);
    chk(out_pin, core_out);
    chk(out_oe, core_oe);
    chk(core_in, in_pin);
    chk(bd_oe_out, bd_oe);
    chk(tdo_oe, 1'b0);
  endtask : t_bypass
  // snapshot without disturbing the pins, then extest applies the preload
  task automatic t_sample();
    ir(`OP_SAMPLE);
    tm.shift(14, 1'b0, P, d);
    chk(d, {2'b00, bd_oe, bd_pin, ~core_oe, core_out, in_pin});
    chk(out_pin, core_out);
    ir(`OP_EXTEST);
    chk(out_pin, P[7:4]);
    chk(out_oe, !P[8]);
    chk(core_in, P[3:0]);
    chk(bd_out, P[12:9]);
    chk(bd_oe_out, P[13]);
    chk(bd_core_in, P[12:9]);
  endtask : t_sample
  // 16 bits through a 14-cell chain: the first two come back out
  task automatic t_extest();
    @(negedge core_clk_in);
    in_pin = 4'h5;
    tm.shift(16, 1'b0, 16'h568f, d);
    chk(d[3:0], in_pin);
    chk(d[12:9], P[12:9]);
    chk(d[15:14], 2'b11);
    chk(out_pin, R[7:4]);
    chk(out_oe, !R[8]);
    chk(core_in, R[3:0]);
    chk(bd_out, R[12:9]);
  endtask : t_extest
  // pins frozen while the core moves, bypass bit in the path
  task automatic t_clamp();
    ir(`OP_CLAMP);
    @(negedge core_clk_in);
    core_out = 4'h1;
    tm.shift(4, 1'b0, 16'h0005, d);
    chk(d, 16'h000a);
    chk(out_pin, R[7:4]);
    chk(core_in, in_pin);
  endtask : t_clamp
  // scan mode, explicit and unlisted bypass codes, both ways back to reset
  task automatic t_codes();
    ir(`OP_INTERNAL_SCAN);
    chk(iscan, 1'b1);
    ir(`OP_BYPASS);
    chk(out_pin, core_out);
    ir(5'h15);
    chk(iscan, 1'b0);
    tm.shift(4, 1'b0, 16'h0009, d);
    chk(d, 16'h0002);
    ir(`OP_EXTEST);
    tm.reset5();
    chk(out_pin, core_out);
    ir(`OP_INTERNAL_SCAN);
    tm.pulse_trst();
    chk(iscan, 1'b0);
    chk(out_pin, core_out);
  endtask : t_codes
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (8) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge core_clk_in);
    tm.reset5();
    t_bypass();
    t_sample();
    t_extest();
    t_clamp();
    t_codes();
    summarize();
  end
  // watchdog about four and a half times the expected run of about 27 us
  initial begin
    #120000;
    errors++;
    summarize();
  end
endmodule : testbench

// ==== verilog/bscan_cells.sv ====
// boundary cell chain: master stages capture and shift, slave stages hold applied values
`include "bscan_map.svh"
module bscan_cells #(
  parameter int LEN = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  bscan_if.chain bus
);
  logic [LEN-1:0] master_reg;
  logic [LEN-1:0] slave_reg;

  // one master/slave pair per cell
  for (genvar i = 0; i < LEN; i++) begin : g_cell
    logic shift_src;
    if (i == LEN - 1) begin : g_top
      assign shift_src = bus.serial_in;
    end else begin : g_mid
      assign shift_src = master_reg[i+1];
    end

    // parallel capture wins over shift; both only on rising tck strobes
    always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
        master_reg[i] <= `CELL_RESET;
      end else if (bus.capture) begin
        master_reg[i] <= bus.cap_vec[i];
      end else if (bus.shift) begin
        master_reg[i] <= shift_src;
      end
    end

    // slave copies the master on the falling-edge update strobe
    always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
        slave_reg[i] <= `CELL_RESET;
      end else if (bus.update) begin
        slave_reg[i] <= master_reg[i];
      end
    end
  end

  assign bus.serial_out = master_reg[0];
  assign bus.slave_vec = slave_reg;
endmodule : bscan_cells

// ==== verilog/bscan_if.sv ====
// strobes and data between the tap control and the boundary cell chain
interface bscan_if #(parameter int LEN = 8);
  logic capture;
  logic shift;
  logic update;
  logic serial_in;
  logic serial_out;
  logic [LEN-1:0] cap_vec;
  logic [LEN-1:0] slave_vec;
  modport ctrl (output capture, output shift, output update, output serial_in, output cap_vec,
                input serial_out, input slave_vec);
  modport chain (input capture, input shift, input update, input serial_in, input cap_vec,
                 output serial_out, output slave_vec);
endinterface : bscan_if

// ==== verilog/bscan_map.svh ====
// named codes, reset values and fixed capture patterns of the boundary-scan logic
`ifndef BSCAN_MAP_SVH
`define BSCAN_MAP_SVH
`define INSTR_WIDTH 5
`define OP_EXTEST 5'h00
`define OP_SAMPLE 5'h01
`define OP_INTERNAL_SCAN 5'h02
`define OP_CLAMP 5'h04
`define OP_BYPASS 5'h1f
`define INSTR_CAPTURE 5'h0d
`define INSTR_RESET 5'h1f
`define BYPASS_CAPTURE 1'b0
`define BYPASS_RESET 1'b0
`define CELL_RESET 1'b0
`define TDO_RESET 1'b0
`define SYNC_RESET 1'b0
`define PIN_RESET 1'b0
`define OE_RESET 1'b0
`define MODE_RESET 1'b0
`define SYNC_TCK 0
`define SYNC_TMS 1
`define SYNC_TDI 2
`define SYNC_TRST 3
`define SYNC_CTRL_W 4
`endif

// ==== verilog/bscan_pkg.sv ====
// types shared by the boundary-scan modules
`include "bscan_map.svh"
package bscan_pkg;
  // gray codes along the data path, then along the instruction path
  typedef enum logic [3:0] {
    test_logic_reset = 4'h0,
    run_idle = 4'h1,
    select_data = 4'h3,
    capture_data = 4'h2,
    shift_data = 4'h6,
    exit1_data = 4'h7,
    pause_data = 4'h5,
    exit2_data = 4'h4,
    update_data = 4'hc,
    select_instr = 4'hd,
    capture_instr = 4'hf,
    shift_instr = 4'he,
    exit1_instr = 4'ha,
    pause_instr = 4'hb,
    exit2_instr = 4'h9,
    update_instr = 4'h8
  } tap_state_e;
  typedef logic [`INSTR_WIDTH-1:0] instr_t;
endpackage : bscan_pkg

// ==== verilog/bscan_tap.sv ====
// boundary-scan tap: controller, instruction register, bypass, tdo and pin muxing
// What this block does
// - extest routes boundary register tdi to tdo
// - extest drives outputs from cells, falling edge
// - extest captures input pins on rising tck
// - sample snapshots pins, outputs record driven values
// - sample update copies master into slave cells
// - code 00010 enables internal scan mode
// - clamp holds pins from cells, bypass path
// - bypass selects one-bit register, normal operation
// - tdi into msb, lsb to tdo
// - serial data passes without inversion
// - cells per pin plus control cells
// - control one means high-z or output
// - no cells for tap pins
// - cells capture pins in parallel, rising tck
// - shifted data applied on falling tck
// - tdo changes on falling tck edge
// - five-bit master/slave instruction register
// - trst low or five tms highs reset
// - state changes only on rising tck, trst low or rst_n_in low
`include "bscan_map.svh"
module bscan_tap
  import bscan_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_BD = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic [N_IN-1:0] in_pin_in,
  output logic [N_IN-1:0] core_in_out,
  input wire logic [N_OUT-1:0] core_out_in,
  input wire logic core_out_oe_in,
  output logic [N_OUT-1:0] out_pin_out,
  output logic out_pin_oe_out,
  input wire logic [N_BD-1:0] bd_pin_in,
  input wire logic [N_BD-1:0] bd_core_out_in,
  input wire logic bd_core_oe_in,
  output logic [N_BD-1:0] bd_pin_out,
  output logic bd_pin_oe_out,
  output logic [N_BD-1:0] bd_core_in_out,
  output logic internal_scan_out
);
  // chain layout from tdo side: inputs, outputs, output control, bidirs, bidir control
  // tap pins are deliberately absent from the chain
  localparam int IN_LO = 0;
  localparam int OUT_LO = IN_LO + N_IN;
  localparam int OUT_CTL = OUT_LO + N_OUT;
  localparam int BD_LO = OUT_CTL + 1;
  localparam int BD_CTL = BD_LO + N_BD;
  localparam int LEN = BD_CTL + 1;
  localparam int SYNC_W = `SYNC_CTRL_W + N_IN + N_BD;

  logic [SYNC_W-1:0] raw_pins;
  logic [SYNC_W-1:0] synced_pins;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic [N_IN-1:0] in_pin_s;
  logic [N_BD-1:0] bd_pin_s;
  logic tck_d_reg;
  logic tck_rise;
  logic tck_fall;
  tap_state_e tap_state_reg;
  tap_state_e tap_next;
  instr_t instr_shift_reg;
  instr_t test_instruction_reg;
  logic sel_extest;
  logic sel_sample;
  logic sel_clamp;
  logic internal_scan_instruction;
  logic bsr_selected;
  logic drive_from_cells;
  logic bypass_reg;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic [N_OUT-1:0] out_pin_reg;
  logic out_pin_oe_reg;
  logic [N_BD-1:0] bd_pin_reg;
  logic bd_pin_oe_reg;
  logic [N_IN-1:0] core_in_reg;
  logic [N_BD-1:0] bd_core_in_reg;
  logic internal_scan_reg;

  bscan_if #(.LEN(LEN)) chain_bus ();

  // every pin from outside passes two flops, tck included
  assign raw_pins = {bd_pin_in, in_pin_in, trst_n_in, tdi_in, tms_in, tck_in};

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_pins),
    .sync_out(synced_pins)
  );

  // unpack the synchronised group; tms and tdi keep their alignment to tck
  // one group means the same two-flop delay for all, so tms and tdi never skew against tck
  assign tck_s = synced_pins[`SYNC_TCK];
  assign tms_s = synced_pins[`SYNC_TMS];
  assign tdi_s = synced_pins[`SYNC_TDI];
  assign trst_n_s = synced_pins[`SYNC_TRST];
  assign in_pin_s = synced_pins[`SYNC_CTRL_W +: N_IN];
  assign bd_pin_s = synced_pins[`SYNC_CTRL_W + N_IN +: N_BD];

  // edge finder on the sampled tck; tck must be well below a quarter of core rate
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tck_d_reg <= `SYNC_RESET;
    end else begin
      tck_d_reg <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // standard sixteen-state walk, steered by tms sampled at the rising edge
  always_comb begin
    tap_next = tap_state_reg;
    unique case (tap_state_reg)
      test_logic_reset: tap_next = tms_s ? test_logic_reset : run_idle;
      run_idle: tap_next = tms_s ? select_data : run_idle;
      select_data: tap_next = tms_s ? select_instr : capture_data;
      capture_data: tap_next = tms_s ? exit1_data : shift_data;
      shift_data: tap_next = tms_s ? exit1_data : shift_data;
      exit1_data: tap_next = tms_s ? update_data : pause_data;
      pause_data: tap_next = tms_s ? exit2_data : pause_data;
      exit2_data: tap_next = tms_s ? update_data : shift_data;
      update_data: tap_next = tms_s ? select_data : run_idle;
      select_instr: tap_next = tms_s ? test_logic_reset : capture_instr;
      capture_instr: tap_next = tms_s ? exit1_instr : shift_instr;
      shift_instr: tap_next = tms_s ? exit1_instr : shift_instr;
      exit1_instr: tap_next = tms_s ? update_instr : pause_instr;
      pause_instr: tap_next = tms_s ? exit2_instr : pause_instr;
      exit2_instr: tap_next = tms_s ? update_instr : shift_instr;
      update_instr: tap_next = tms_s ? select_data : run_idle;
    endcase
  end

  // state register; trst low forces reset regardless of tck
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !trst_n_s) begin
      tap_state_reg <= test_logic_reset;
    end else if (tck_rise) begin
      tap_state_reg <= tap_next;
    end
  end

  // instruction master stage: fixed capture pattern, then shift toward tdo
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      instr_shift_reg <= `INSTR_CAPTURE;
    end else if (tck_rise) begin
      if (tap_state_reg == capture_instr) begin
        instr_shift_reg <= `INSTR_CAPTURE;
      end else if (tap_state_reg == shift_instr) begin
        instr_shift_reg <= {tdi_s, instr_shift_reg[`INSTR_WIDTH-1:1]};
      end
    end
  end

  // instruction slave stage: new code acts only once latched on falling tck
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !trst_n_s) begin
      test_instruction_reg <= `INSTR_RESET;
    end else if (tck_fall) begin
      if (tap_state_reg == test_logic_reset) begin
        test_instruction_reg <= `INSTR_RESET;
      end else if (tap_state_reg == update_instr) begin
        test_instruction_reg <= instr_shift_reg;
      end
    end
  end

  // decode; anything not listed falls through to bypass with pins in normal use
  // decoding the slave stage means codes passing through the master mid-shift never act
  assign sel_extest = (test_instruction_reg == `OP_EXTEST);
  assign sel_sample = (test_instruction_reg == `OP_SAMPLE);
  assign sel_clamp = (test_instruction_reg == `OP_CLAMP);
  assign internal_scan_instruction = (test_instruction_reg == `OP_INTERNAL_SCAN);
  assign bsr_selected = sel_extest | sel_sample;
  assign drive_from_cells = sel_extest | sel_clamp;

  // one-bit bypass path, loads zero at capture
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bypass_reg <= `BYPASS_RESET;
    end else if (tck_rise) begin
      if (tap_state_reg == capture_data) begin
        bypass_reg <= `BYPASS_CAPTURE;
      end else if (tap_state_reg == shift_data) begin
        bypass_reg <= tdi_s;
      end
    end
  end

  // chain strobes; gating by selection keeps the cells quiet under bypass and clamp
  assign chain_bus.capture = tck_rise & (tap_state_reg == capture_data) & bsr_selected;
  assign chain_bus.shift = tck_rise & (tap_state_reg == shift_data) & bsr_selected;
  assign chain_bus.update = tck_fall & (tap_state_reg == update_data) & bsr_selected;
  assign chain_bus.serial_in = tdi_s;

  // capture sources: input pins, values being driven, and the current enables
  assign chain_bus.cap_vec[IN_LO +: N_IN] = in_pin_s;
  assign chain_bus.cap_vec[OUT_LO +: N_OUT] = out_pin_reg;
  assign chain_bus.cap_vec[OUT_CTL] = ~out_pin_oe_reg;
  assign chain_bus.cap_vec[BD_LO +: N_BD] = bd_pin_s;
  assign chain_bus.cap_vec[BD_CTL] = bd_pin_oe_reg;

  bscan_cells #(
    .LEN(LEN)
  ) u_cells (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .bus(chain_bus)
  );

  // tdo enable: driven only in the shift states, floating otherwise; moves on falling tck
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tdo_oe_reg <= `OE_RESET;
    end else if (tck_fall) begin
      tdo_oe_reg <= (tap_state_reg == shift_data) || (tap_state_reg == shift_instr);
    end
  end

  // tdo data moves on falling tck, half a period clear of the master's sampling rise
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tdo_reg <= `TDO_RESET;
    end else if (tck_fall) begin
      if (tap_state_reg == shift_instr) begin
        tdo_reg <= instr_shift_reg[0];
      end else if (bsr_selected) begin
        tdo_reg <= chain_bus.serial_out;
      end else begin
        tdo_reg <= bypass_reg;
      end
    end
  end

  // output pin data: cell slaves only change on falling tck, so pins driven from them do too
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      out_pin_reg <= {N_OUT{`PIN_RESET}};
    end else if (drive_from_cells) begin
      out_pin_reg <= chain_bus.slave_vec[OUT_LO +: N_OUT];
    end else begin
      out_pin_reg <= core_out_in;
    end
  end

  // output group enable: a control one floats the group, hence the inversion
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      out_pin_oe_reg <= `OE_RESET;
    end else if (drive_from_cells) begin
      out_pin_oe_reg <= ~chain_bus.slave_vec[OUT_CTL];
    end else begin
      out_pin_oe_reg <= core_out_oe_in;
    end
  end

  // bidirectional pin data from the cells under extest and clamp, from the core otherwise
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bd_pin_reg <= {N_BD{`PIN_RESET}};
    end else if (drive_from_cells) begin
      bd_pin_reg <= chain_bus.slave_vec[BD_LO +: N_BD];
    end else begin
      bd_pin_reg <= bd_core_out_in;
    end
  end

  // bidirectional direction: control one selects driving
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bd_pin_oe_reg <= `OE_RESET;
    end else if (drive_from_cells) begin
      bd_pin_oe_reg <= chain_bus.slave_vec[BD_CTL];
    end else begin
      bd_pin_oe_reg <= bd_core_oe_in;
    end
  end

  // core-side inputs see cell values under extest, real pins otherwise
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      core_in_reg <= {N_IN{`PIN_RESET}};
    end else if (sel_extest) begin
      core_in_reg <= chain_bus.slave_vec[IN_LO +: N_IN];
    end else begin
      core_in_reg <= in_pin_s;
    end
  end

  // bidirectional pins seen by the core; clamp leaves the core on the real pins
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bd_core_in_reg <= {N_BD{`PIN_RESET}};
    end else if (sel_extest) begin
      bd_core_in_reg <= chain_bus.slave_vec[BD_LO +: N_BD];
    end else begin
      bd_core_in_reg <= bd_pin_s;
    end
  end

  // internal scan enable, registered so the core sees a clean level
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      internal_scan_reg <= `MODE_RESET;
    end else begin
      internal_scan_reg <= internal_scan_instruction;
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;
  assign out_pin_out = out_pin_reg;
  assign out_pin_oe_out = out_pin_oe_reg;
  assign bd_pin_out = bd_pin_reg;
  assign bd_pin_oe_out = bd_pin_oe_reg;
  assign core_in_out = core_in_reg;
  assign bd_core_in_out = bd_core_in_reg;
  assign internal_scan_out = internal_scan_reg;
endmodule : bscan_tap

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser for a group of pins from outside the core clock domain
`include "bscan_map.svh"
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second one
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stage1_reg <= {WIDTH{`SYNC_RESET}};
      stage2_reg <= {WIDTH{`SYNC_RESET}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : pin_sync
